// ===== inc/sswd_pkg.sv
// Shared constants and types of the watchdog and supply supervisor.
// Assumes one 25 MHz clock; every timing count is derived here.
package sswd_pkg;

  localparam int unsigned CLK_MHZ         = 25;
  // Times in their own units, counts derived from the clock rate
  localparam int unsigned DEGLITCH_US     = 180;
  localparam int unsigned DEGLITCH_CYC    = DEGLITCH_US * CLK_MHZ;
  localparam int unsigned DEBOUNCE_US     = 125;
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned POR_SAMPLE_MS   = 1;
  localparam int unsigned POR_SAMPLE_CYC  = POR_SAMPLE_MS * 1000 * CLK_MHZ;
  localparam int unsigned WD_TICK_MS      = 1;
  localparam int unsigned WD_TICK_CYC     = WD_TICK_MS * 1000 * CLK_MHZ;

  localparam int unsigned WD_PERIOD_W     = 7;
  localparam logic        WD_MODE_PERIODIC = 1'b0;
  localparam logic        WD_MODE_IRQ      = 1'b1;

  // Identification registers, select codes on the read port
  localparam logic [1:0]  ID_SEL_PROD_HIGH = 2'h0;
  localparam logic [1:0]  ID_SEL_PROD_LOW  = 2'h1;
  localparam logic [1:0]  ID_SEL_SILICON   = 2'h2;
  localparam logic [1:0]  ID_SEL_CONFIG    = 2'h3;

  typedef struct packed {
    logic                   lock;
    logic                   enable;
    logic                   mode;
    logic [WD_PERIOD_W-1:0] period;
  } sswd_wd_cfg_t;

  typedef struct packed {
    logic       enable;
    logic [7:0] threshold;
  } sswd_mon_cfg_t;

  localparam sswd_wd_cfg_t  WD_CFG_RST  = '{lock: 1'b0, enable: 1'b0,
                                            mode: WD_MODE_PERIODIC,
                                            period: 7'h7f};
  localparam sswd_mon_cfg_t MON_CFG_RST = '{enable: 1'b1,
                                            threshold: 8'h00};

  typedef enum logic [4:0] {
    PWR_NO_SUPPLY = 5'b00001,
    PWR_BACKUP    = 5'b00010,
    PWR_OFF       = 5'b00100,
    PWR_ACTIVE    = 5'b01000,
    PWR_SLEEP     = 5'b10000
  } sswd_pwr_state_t;

endpackage : sswd_pkg

// ===== src/sswd_timer.sv
// Free-running interval counter: pulses done every LIMIT cycles of run.
// Assumes run is synchronous; dropping run restarts the interval.
module sswd_timer
  import sswd_pkg::*;
#(
  parameter int unsigned LIMIT = 16
) (
  input  wire logic clk,     // System clock
  input  wire logic arst_n,  // Asynchronous reset, active low
  input  wire logic run,     // Count while high
  output logic      done     // One-cycle pulse at end of interval
);

  localparam logic [15:0] LAST = 16'(LIMIT - 1);

  logic [15:0] cnt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt  <= 16'h0000;
      done <= 1'b0;
    end else if (!run) begin
      cnt  <= 16'h0000;
      done <= 1'b0;
    end else if (cnt == LAST) begin
      cnt  <= 16'h0000;
      done <= 1'b1;
    end else begin
      cnt  <= cnt + 16'h0001;
      done <= 1'b0;
    end
  end

endmodule : sswd_timer

// ===== src/sswd_id_regs.sv
// Read-only identification registers behind a two-bit select.
// Assumes the reader samples data one cycle after changing sel.
module sswd_id_regs
  import sswd_pkg::*;
#(
  parameter logic [7:0] PROD_HIGH = 8'ha5,  // Arbitrary neutral value
  parameter logic [7:0] PROD_LOW  = 8'h5a,  // Arbitrary neutral value
  parameter logic [7:0] SILICON   = 8'h3c,  // Arbitrary neutral value
  parameter logic [7:0] CONFIG    = 8'hc3   // Arbitrary neutral value
) (
  input  wire logic       clk,     // System clock
  input  wire logic       arst_n,  // Asynchronous reset, active low
  input  wire logic [1:0] sel,     // Register select
  output logic      [7:0] data     // Registered read data
);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data <= 8'h00;
    end else begin
      case (sel)
        ID_SEL_PROD_HIGH: data <= PROD_HIGH;
        ID_SEL_PROD_LOW:  data <= PROD_LOW;
        ID_SEL_SILICON:   data <= SILICON;
        ID_SEL_CONFIG:    data <= CONFIG;
        default:          data <= 8'h00;
      endcase
    end
  end

endmodule : sswd_id_regs

// ===== src/sswd_supervisor.sv
// Watchdog and supply supervisor: watchdog timer, power state machine,
// supply monitor comparator handling and identification registers.
// Assumes comparator outputs and host strobes are synchronous to CLK.

// Overview of operation
// - Watchdog runs either in periodic mode or in interrupt mode.
// - Periodic mode raises the watchdog interrupt when the counter equals one.
// - Periodic shutdown at count equal to period unless interrupt was cleared.
// - Clearing does not reset the counter; it wraps to zero after period.
// - While reset output is low, counter and interrupt stay at zero.
// - Interrupt mode: any new interrupt source restarts the counter.
// - Interrupt mode: shutdown if interrupt line still high at period end.
// - Host clears all sources in time; counter is then discarded.
// - Watchdog is disabled after reset until software sets enable.
// - Once lock is set, the enable selection can no longer change.
// - Only device reset returns enable and lock to defaults.
// - Below power-on level stay in no-supply; above it go to backup.
// - Backup moves to off when supply rises above low threshold.
// - Off, active or sleep go to backup when supply falls below low.
// - Fall below low is deglitched 180 us, then switchable regulators drop together.
// - Off to active is gated by the monitor comparator, at startup threshold until the first startup.
// - Monitor comparator disabled after startup; software may then reenable.
// - Monitor comparator events are debounced for 125 us.
// - Low and startup thresholds are fixed; software cannot alter them.
// - Bus power detect, with supply present, interrupts, wakes or powers on.
// - Falling supply is checked against power-on level once per 1 ms.
// - Read-only product, silicon and configuration identification bytes.
module sswd_supervisor
  import sswd_pkg::*;
#(
  parameter int unsigned WD_TICK     = WD_TICK_CYC,     // Watchdog time base
  parameter int unsigned DEGLITCH    = DEGLITCH_CYC,    // Low-supply deglitch
  parameter int unsigned POR_SAMPLE  = POR_SAMPLE_CYC,  // POR sample interval
  parameter logic [7:0]  LOW_TH      = 8'h40,  // Factory low-supply level
  parameter logic [7:0]  STARTUP_TH  = 8'h60   // Factory startup level
) (
  input  wire logic            CLK,              // 25 MHz clock
  input  wire logic            ARST_N,           // Async reset, active low
  input  wire logic            RESET_OUT_N,      // System reset output level
  input  wire logic            WD_CTRL_WE,       // Watchdog control write
  input  wire sswd_wd_cfg_t    WD_CTRL_WDATA,    // Watchdog control data
  input  wire logic            WD_IRQ_CLEAR,     // Clear watchdog interrupt
  input  wire logic            INT_LINE,         // Interrupt line asserted
  input  wire logic            INT_SOURCE_NEW,   // New interrupt source pulse
  input  wire logic            MON_CFG_WE,       // Monitor config write
  input  wire sswd_mon_cfg_t   MON_CFG_WDATA,    // Monitor config data
  input  wire logic            SUPPLY_ABOVE_POR, // Main supply above POR
  input  wire logic            SUPPLY_ABOVE_LOW, // Main supply above low
  input  wire logic            MONITOR_ABOVE,    // Monitor comparator output
  input  wire logic            BUS_POWER_DETECT, // Bus power comparator
  input  wire logic            POWER_ON_REQ,     // Power-on request
  input  wire logic            SLEEP_REQ,        // Sleep request
  input  wire logic [1:0]      ID_SEL,           // Identification select
  output sswd_wd_cfg_t         WD_CTRL_RDATA,    // Watchdog control readback
  output logic                 WD_IRQ,           // Watchdog interrupt
  output logic                 SHUTDOWN_REQ,     // Shutdown pulse
  output sswd_pwr_state_t      POWER_STATE,      // Power state
  output logic                 REGULATORS_EN,    // Switchable regulators on
  output logic                 ALWAYS_ON_EN,     // Always-on regulator on
  output logic                 MON_ENABLE,       // Monitor comparator on
  output logic [7:0]           MON_THRESHOLD,    // Monitor threshold in use
  output logic [7:0]           LOW_THRESHOLD,    // Low-supply threshold
  output logic                 MON_EVENT,        // Monitor interrupt pulse
  output logic                 BUS_DET_EVENT,    // Bus detect interrupt pulse
  output logic [7:0]           ID_DATA           // Identification read data
);

  sswd_wd_cfg_t           wd_cfg;
  logic [WD_PERIOD_W-1:0] wd_cnt;
  logic [WD_PERIOD_W-1:0] next_wd_cnt;
  logic                   wd_cleared;
  logic                   wd_run;
  logic                   wd_tick;
  logic                   wd_live;
  logic                   int_line_q;
  logic                   int_restart;
  logic                   wd_at_one;
  logic                   wd_periodic_end;
  logic                   wd_int_end;
  sswd_pwr_state_t        state;
  sswd_pwr_state_t        next_state;
  logic                   por_ok;
  logic                   por_tick;
  logic                   low_run;
  logic                   low_done;
  logic                   bus_q;
  logic                   bus_rise;
  sswd_mon_cfg_t          mon_cfg;
  logic                   mon_startup;
  logic                   mon_q;
  logic                   mon_primed;
  logic                   mon_change;
  logic                   deb_busy;
  logic                   deb_done;

  sswd_timer #(.LIMIT(WD_TICK)) u_wd_tick (
    .clk    (CLK),
    .arst_n (ARST_N),
    .run    (wd_live),
    .done   (wd_tick)
  );

  sswd_timer #(.LIMIT(POR_SAMPLE)) u_por_sample (
    .clk    (CLK),
    .arst_n (ARST_N),
    .run    (1'b1),
    .done   (por_tick)
  );

  sswd_timer #(.LIMIT(DEGLITCH)) u_deglitch (
    .clk    (CLK),
    .arst_n (ARST_N),
    .run    (low_run),
    .done   (low_done)
  );

  sswd_timer #(.LIMIT(DEBOUNCE_CYC)) u_debounce (
    .clk    (CLK),
    .arst_n (ARST_N),
    .run    (deb_busy),
    .done   (deb_done)
  );

  sswd_id_regs u_id (
    .clk    (CLK),
    .arst_n (ARST_N),
    .sel    (ID_SEL),
    .data   (ID_DATA)
  );

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wd_cfg <= WD_CFG_RST;
    end else if (WD_CTRL_WE) begin
      if (!wd_cfg.lock) begin
        wd_cfg <= WD_CTRL_WDATA;
      end else begin
        wd_cfg.mode   <= WD_CTRL_WDATA.mode;
        wd_cfg.period <= WD_CTRL_WDATA.period;
      end
    end
  end

  assign WD_CTRL_RDATA = wd_cfg;

  // counting needs enable and released reset output
  assign wd_live     = wd_cfg.enable && RESET_OUT_N;
  assign next_wd_cnt = (wd_cnt >= wd_cfg.period) ? '0 : wd_cnt + 7'h01;
  assign int_restart = INT_SOURCE_NEW || (INT_LINE && !int_line_q);

  assign wd_at_one = wd_live && wd_cfg.mode == WD_MODE_PERIODIC &&
                     wd_tick && next_wd_cnt == 7'h01;
  // end of period without a clear; a clear in this cycle still counts
  assign wd_periodic_end = wd_live && wd_cfg.mode == WD_MODE_PERIODIC &&
                           wd_tick && wd_cfg.period != '0 &&
                           next_wd_cnt == wd_cfg.period &&
                           !wd_cleared && !WD_IRQ_CLEAR;
  // line still asserted at the end of the period
  assign wd_int_end = wd_live && wd_cfg.mode == WD_MODE_IRQ && wd_run &&
                      wd_tick && INT_LINE && !int_restart &&
                      wd_cnt + 7'h01 == wd_cfg.period;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      int_line_q <= 1'b0;
    end else begin
      int_line_q <= INT_LINE;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wd_cnt <= '0;
      wd_run <= 1'b0;
    end else if (!wd_live) begin
      wd_cnt <= '0;
      wd_run <= 1'b0;
    end else if (wd_cfg.mode == WD_MODE_PERIODIC) begin
      wd_run <= 1'b0;
      if (wd_tick) begin
        wd_cnt <= next_wd_cnt;
      end
    end else if (int_restart) begin
      wd_cnt <= '0;
      wd_run <= 1'b1;
    end else if (!INT_LINE || wd_int_end) begin
      wd_cnt <= '0;
      wd_run <= 1'b0;
    end else if (wd_run && wd_tick) begin
      wd_cnt <= wd_cnt + 7'h01;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wd_cleared <= 1'b0;
    end else if (!wd_live || wd_at_one) begin
      wd_cleared <= 1'b0;
    end else if (WD_IRQ_CLEAR) begin
      wd_cleared <= 1'b1;
    end
  end

  // interrupt held low while not live; set wins over clear
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      WD_IRQ <= 1'b0;
    end else if (!wd_live) begin
      WD_IRQ <= 1'b0;
    end else if (wd_at_one) begin
      WD_IRQ <= 1'b1;
    end else if (WD_IRQ_CLEAR) begin
      WD_IRQ <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SHUTDOWN_REQ <= 1'b0;
    end else begin
      SHUTDOWN_REQ <= wd_periodic_end || wd_int_end;
    end
  end

  // rising supply seen at once, falling only at the sample instant
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      por_ok <= 1'b0;
    end else if (SUPPLY_ABOVE_POR) begin
      por_ok <= 1'b1;
    end else if (por_tick) begin
      por_ok <= 1'b0;
    end
  end

  // deglitch runs only while a fall below low is pending
  assign low_run = !SUPPLY_ABOVE_LOW &&
                   (state == PWR_OFF || state == PWR_ACTIVE ||
                    state == PWR_SLEEP);

  // bus detect only with supply present
  assign bus_rise = por_ok && BUS_POWER_DETECT && !bus_q;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bus_q <= 1'b0;
    end else begin
      bus_q <= BUS_POWER_DETECT;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      PWR_NO_SUPPLY: begin
        if (por_ok) begin
          next_state = PWR_BACKUP;
        end
      end
      PWR_BACKUP: begin
        if (SUPPLY_ABOVE_LOW) begin
          next_state = PWR_OFF;
        end
      end
      PWR_OFF: begin
        if (low_done) begin
          next_state = PWR_BACKUP;
        end else if ((POWER_ON_REQ || bus_rise) && MONITOR_ABOVE) begin
          next_state = PWR_ACTIVE;
        end
      end
      PWR_ACTIVE: begin
        if (low_done) begin
          next_state = PWR_BACKUP;
        end else if (SHUTDOWN_REQ) begin
          next_state = PWR_OFF;
        end else if (SLEEP_REQ) begin
          next_state = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (low_done) begin
          next_state = PWR_BACKUP;
        end else if (SHUTDOWN_REQ) begin
          next_state = PWR_OFF;
        end else if (bus_rise || POWER_ON_REQ) begin
          next_state = PWR_ACTIVE;
        end
      end
      default: next_state = PWR_NO_SUPPLY;
    endcase
    if (!por_ok) begin
      next_state = PWR_NO_SUPPLY;
    end
  end

  // switchable regulators drop together with the move to backup
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state         <= PWR_NO_SUPPLY;
      REGULATORS_EN <= 1'b0;
      ALWAYS_ON_EN  <= 1'b0;
    end else begin
      state         <= next_state;
      REGULATORS_EN <= next_state == PWR_ACTIVE || next_state == PWR_SLEEP;
      ALWAYS_ON_EN  <= next_state != PWR_NO_SUPPLY;
    end
  end

  assign POWER_STATE = state;

  // auto disable at startup, software may reenable afterwards
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mon_cfg     <= MON_CFG_RST;
      mon_startup <= 1'b1;
    end else if (state == PWR_OFF && next_state == PWR_ACTIVE &&
                 mon_startup) begin
      mon_cfg.enable <= 1'b0;
      mon_startup    <= 1'b0;
    end else if (MON_CFG_WE && !mon_startup) begin
      mon_cfg <= MON_CFG_WDATA;
    end
  end

  // factory thresholds have no write path
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MON_THRESHOLD <= STARTUP_TH;
      LOW_THRESHOLD <= LOW_TH;
      MON_ENABLE    <= 1'b1;
    end else begin
      MON_THRESHOLD <= mon_startup ? STARTUP_TH : mon_cfg.threshold;
      LOW_THRESHOLD <= LOW_TH;
      MON_ENABLE    <= mon_cfg.enable;
    end
  end

  // No hysteresis: every crossing is an edge; priming avoids a reset edge
  assign mon_change = mon_cfg.enable && mon_primed &&
                      (MONITOR_ABOVE != mon_q);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mon_q         <= 1'b0;
      mon_primed    <= 1'b0;
      deb_busy      <= 1'b0;
      MON_EVENT     <= 1'b0;
      BUS_DET_EVENT <= 1'b0;
    end else begin
      mon_q         <= MONITOR_ABOVE;
      mon_primed    <= 1'b1;
      MON_EVENT     <= mon_change && !deb_busy;
      BUS_DET_EVENT <= bus_rise;
      if (mon_change && !deb_busy) begin
        deb_busy <= 1'b1;
      end else if (deb_done) begin
        deb_busy <= 1'b0;
      end
    end
  end

  // Checking helpers
  logic [15:0] below_run;
  logic [15:0] mon_gap;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      below_run <= 16'h0000;
      mon_gap   <= 16'hffff;
    end else begin
      below_run <= low_run ? below_run + {15'h0000, below_run != 16'hffff}
                           : 16'h0000;
      mon_gap   <= MON_EVENT ? 16'h0000
                             : mon_gap + {15'h0000, mon_gap != 16'hffff};
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  wd_irq_one_a: assert property (
    $rose(WD_IRQ) |-> wd_cnt == 7'h01 && wd_cfg.mode == WD_MODE_PERIODIC)
    else $error("watchdog interrupt not at count one");
  periodic_shutdown_a: assert property (
    SHUTDOWN_REQ && wd_cfg.mode == WD_MODE_PERIODIC |->
      wd_cnt == wd_cfg.period && !wd_cleared)
    else $error("periodic shutdown at wrong count or after clear");
  reset_hold_a: assert property (
    !RESET_OUT_N |=> wd_cnt == '0 && !WD_IRQ)
    else $error("watchdog ran while reset output low");
  wd_disabled_a: assert property (
    !wd_cfg.enable |=> wd_cnt == '0 && !WD_IRQ && !wd_run)
    else $error("watchdog active while disabled");
  enable_lock_a: assert property (
    wd_cfg.lock |=> wd_cfg.lock && $stable(wd_cfg.enable))
    else $error("locked enable changed");
  int_discard_a: assert property (
    wd_run && !INT_LINE && !INT_SOURCE_NEW |=> !wd_run && wd_cnt == '0)
    else $error("watchdog count kept after sources cleared");
  no_supply_a: assert property (
    !por_ok |=> state == PWR_NO_SUPPLY && !ALWAYS_ON_EN)
    else $error("left no-supply without supply");
  low_deglitch_a: assert property (
    state == PWR_BACKUP && $past(low_run) |->
      $past(below_run) >= 16'(DEGLITCH - 1) && !REGULATORS_EN)
    else $error("backup entered before deglitch elapsed");
  mon_debounce_a: assert property (
    MON_EVENT |-> mon_gap >= 16'(DEBOUNCE_CYC))
    else $error("monitor event inside debounce window");
  startup_off_a: assert property (
    state == PWR_OFF && next_state == PWR_ACTIVE && mon_startup |=>
      !mon_cfg.enable ##1 !MON_ENABLE)
    else $error("monitor comparator not disabled after startup");

  periodic_sd_c: cover property (wd_periodic_end);
  int_sd_c: cover property (wd_int_end);
  backup_c: cover property (state == PWR_ACTIVE ##1 state == PWR_BACKUP);
  mon_event_c: cover property (MON_EVENT);

endmodule : sswd_supervisor

// ===== dv/sswd_host_model.sv
// Host stand-in that services the watchdog interrupt.
// Assumes the supervisor's clock and reset; respond low keeps it silent.
module sswd_host_model
  import sswd_pkg::*;
#(
  parameter int unsigned DELAY = 2  // Cycles from interrupt to clear
) (
  input  wire logic clk,       // System clock
  input  wire logic arst_n,    // Async reset, active low
  input  wire logic wd_irq,    // Watchdog interrupt seen
  input  wire logic respond,   // Low makes the host ignore it
  output logic      irq_clear  // One-cycle clear pulse
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] wait_cnt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_cnt  <= 4'h0;
      irq_clear <= 1'b0;
    end else begin
      irq_clear <= (wait_cnt == 4'h1);
      if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (wd_irq && respond && !irq_clear) begin
        wait_cnt <= DELAY[3:0];
      end
    end
  end
endmodule : sswd_host_model

// ===== dv/sswd_supervisor_test.sv
// Self-checking bench for the watchdog and supply supervisor.
// Assumes shortened time bases: tick 4, deglitch 8, POR sample 16;
// the monitor debounce keeps its full length, so the run waits it out.
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin \
  mismatches++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end

module sswd_supervisor_test
  import sswd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic CLK = 1'b0, ARST_N = 1'b0, RESET_OUT_N = 1'b0, WD_CTRL_WE = 1'b0;
  logic INT_LINE = 1'b0, INT_SOURCE_NEW = 1'b0, MON_CFG_WE = 1'b0;
  logic SUPPLY_ABOVE_POR = 1'b0, SUPPLY_ABOVE_LOW = 1'b0;
  logic MONITOR_ABOVE = 1'b0, BUS_POWER_DETECT = 1'b0;
  logic POWER_ON_REQ = 1'b0, SLEEP_REQ = 1'b0, respond = 1'b1;
  logic [1:0] ID_SEL = 2'h0;
  sswd_wd_cfg_t WD_CTRL_WDATA = WD_CFG_RST, WD_CTRL_RDATA;
  sswd_mon_cfg_t MON_CFG_WDATA = MON_CFG_RST;
  sswd_pwr_state_t POWER_STATE;
  logic WD_IRQ_CLEAR, WD_IRQ, SHUTDOWN_REQ, REGULATORS_EN, ALWAYS_ON_EN;
  logic MON_ENABLE, MON_EVENT, BUS_DET_EVENT, irq_q = 1'b0;
  logic [7:0] MON_THRESHOLD, LOW_THRESHOLD, ID_DATA;
  logic [7:0] ids [4] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3};
  int mismatches = 0, tests_run = 0, cycles = 0, base = 0;
  int n_shut = 0, n_mon = 0, n_bus = 0, n_irq = 0;

  sswd_supervisor #(.WD_TICK(4), .DEGLITCH(8), .POR_SAMPLE(16)) uut (
    .CLK, .ARST_N, .RESET_OUT_N, .WD_CTRL_WE, .WD_CTRL_WDATA, .WD_IRQ_CLEAR,
    .INT_LINE, .INT_SOURCE_NEW, .MON_CFG_WE, .MON_CFG_WDATA, .SUPPLY_ABOVE_POR,
    .SUPPLY_ABOVE_LOW, .MONITOR_ABOVE, .BUS_POWER_DETECT, .POWER_ON_REQ,
    .SLEEP_REQ, .ID_SEL, .WD_CTRL_RDATA, .WD_IRQ, .SHUTDOWN_REQ, .POWER_STATE,
    .REGULATORS_EN, .ALWAYS_ON_EN, .MON_ENABLE, .MON_THRESHOLD, .LOW_THRESHOLD,
    .MON_EVENT, .BUS_DET_EVENT, .ID_DATA);

  sswd_host_model #(.DELAY(2)) host (.clk(CLK), .arst_n(ARST_N),
    .wd_irq(WD_IRQ), .respond(respond), .irq_clear(WD_IRQ_CLEAR));

  always #20 CLK = ~CLK;

  // Pulses are counted at the edge after they appear
  always @(posedge CLK) begin
    cycles++;
    if (SHUTDOWN_REQ === 1'b1) n_shut++;
    if (MON_EVENT === 1'b1) n_mon++;
    if (BUS_DET_EVENT === 1'b1) n_bus++;
    if (WD_IRQ === 1'b1 && irq_q !== 1'b1) n_irq++;
    irq_q <= WD_IRQ;
    if (cycles == 6000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report;
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic tk(input int n);
    repeat (n) @(negedge CLK);
  endtask : tk

  task automatic wr_wd(input sswd_wd_cfg_t c);
    @(posedge CLK);
    WD_CTRL_WE    <= 1'b1;
    WD_CTRL_WDATA <= c;
    @(posedge CLK);
    WD_CTRL_WE <= 1'b0;
    tk(1);
  endtask : wr_wd

  // Bounded wait for a power state, then compare
  task automatic wst(input sswd_pwr_state_t s, input int n);
    repeat (n) if (POWER_STATE !== s) @(negedge CLK);
    `CHK(POWER_STATE, s)
  endtask : wst

  task automatic pulse_src;
    @(posedge CLK);
    INT_LINE       <= 1'b1;
    INT_SOURCE_NEW <= 1'b1;
    @(posedge CLK);
    INT_SOURCE_NEW <= 1'b0;
  endtask : pulse_src

  initial begin
    repeat (4) @(posedge CLK);
    ARST_N <= 1'b1;
    tk(1);
    `CHK(WD_CTRL_RDATA, WD_CFG_RST)
    `CHK(MON_THRESHOLD, 8'h60)
    `CHK(LOW_THRESHOLD, 8'h40)
    `CHK(POWER_STATE, PWR_NO_SUPPLY)
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK);
      ID_SEL <= i[1:0];
      tk(2);
      `CHK(ID_DATA, ids[i])
    end
    @(posedge CLK);
    SUPPLY_ABOVE_POR <= 1'b1;
    wst(PWR_BACKUP, 4);
    @(posedge CLK);
    SUPPLY_ABOVE_LOW <= 1'b1;
    wst(PWR_OFF, 4);
    @(posedge CLK);
    POWER_ON_REQ <= 1'b1;
    tk(6);
    `CHK(POWER_STATE, PWR_OFF)
    base = n_mon;
    @(posedge CLK);
    MONITOR_ABOVE <= 1'b1;
    wst(PWR_ACTIVE, 4);
    @(posedge CLK);
    POWER_ON_REQ <= 1'b0;
    tk(2);
    `CHK(MON_ENABLE, 1'b0)
    `CHK(n_mon, base + 1)
    @(posedge CLK);
    MON_CFG_WE    <= 1'b1;
    MON_CFG_WDATA <= '{enable: 1'b1, threshold: 8'h55};
    @(posedge CLK);
    MON_CFG_WE <= 1'b0;
    tk(2);
    `CHK({MON_ENABLE, MON_THRESHOLD}, 9'h155)
    // Still inside the window opened by the startup crossing
    base = n_mon;
    @(posedge CLK);
    MONITOR_ABOVE <= 1'b0;
    @(posedge CLK);
    MONITOR_ABOVE <= 1'b1;
    tk(20);
    `CHK(n_mon, base)
    tk(3130);
    @(posedge CLK);
    MONITOR_ABOVE <= 1'b0;
    @(posedge CLK);
    MONITOR_ABOVE <= 1'b1;
    tk(20);
    `CHK(n_mon, base + 1)
    @(posedge CLK);
    SUPPLY_ABOVE_LOW <= 1'b0;
    tk(5);
    `CHK(POWER_STATE, PWR_ACTIVE)
    wst(PWR_BACKUP, 10);
    tk(2);
    `CHK({REGULATORS_EN, ALWAYS_ON_EN}, 2'h1)
    @(posedge CLK);
    SUPPLY_ABOVE_LOW <= 1'b1;
    wst(PWR_OFF, 4);
    base = n_bus;
    @(posedge CLK);
    BUS_POWER_DETECT <= 1'b1;
    wst(PWR_ACTIVE, 4);
    tk(2);
    `CHK(n_bus, base + 1)
    @(posedge CLK);
    SLEEP_REQ        <= 1'b1;
    BUS_POWER_DETECT <= 1'b0;
    wst(PWR_SLEEP, 4);
    @(posedge CLK);
    SLEEP_REQ        <= 1'b0;
    BUS_POWER_DETECT <= 1'b1;
    wst(PWR_ACTIVE, 4);
    wr_wd(10'h103);
    tk(40);
    `CHK(n_irq, 0)
    @(posedge CLK);
    RESET_OUT_N <= 1'b1;
    tk(60);
    `CHK(n_irq inside {3, 4}, 1'b1)
    `CHK(n_shut, 0)
    @(posedge CLK);
    respond <= 1'b0;
    repeat (40) if (n_shut == 0) @(negedge CLK);
    `CHK(n_shut, 1)
    wr_wd(10'h183);
    wst(PWR_OFF, 2);
    base = n_shut;
    pulse_src();
    tk(4);
    @(posedge CLK);
    INT_LINE <= 1'b0;
    tk(30);
    `CHK(n_shut, base)
    pulse_src();
    tk(20);
    `CHK(n_shut, base + 1)
    @(posedge CLK);
    INT_LINE <= 1'b0;
    wr_wd(10'h305);
    wr_wd(10'h082);
    `CHK(WD_CTRL_RDATA, 10'h382)
    @(posedge CLK);
    SUPPLY_ABOVE_POR <= 1'b0;
    wst(PWR_NO_SUPPLY, 20);
    @(posedge CLK);
    ARST_N <= 1'b0;
    tk(2);
    @(posedge CLK);
    ARST_N <= 1'b1;
    tk(1);
    `CHK(WD_CTRL_RDATA, WD_CFG_RST)
    final_report();
  end
endmodule : sswd_supervisor_test
